// *** dcs_pkg.sv ***
// Package for the port device control and status register pair.
// Assumes one instance of the register block per switch port.
`default_nettype none
package dcs_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] DCS_ADDR_CTRL_STATUS = 12'h0C8;
    localparam int DCS_ADDR_WIDTH = 12;

    // ****************************************************************
    // Control field positions (low half of the word)
    // ****************************************************************
    localparam int DCS_BIT_CORR_EN = 0;
    localparam int DCS_BIT_NONFATAL_EN = 1;
    localparam int DCS_BIT_FATAL_EN = 2;
    localparam int DCS_BIT_UNSUP_EN = 3;
    localparam int DCS_BIT_RELAXED = 4;
    localparam int DCS_MPS_LSB = 5;
    localparam int DCS_MPS_MSB = 7;
    localparam int DCS_BIT_EXT_TAG = 8;
    localparam int DCS_BIT_PHANTOM = 9;
    localparam int DCS_BIT_AUX_PM = 10;
    localparam int DCS_BIT_NO_SNOOP = 11;
    localparam int DCS_MRRS_LSB = 12;
    localparam int DCS_MRRS_MSB = 14;

    // ****************************************************************
    // Status field positions (high half of the word)
    // ****************************************************************
    localparam int DCS_ERR_LSB = 16;
    localparam int DCS_ERR_MSB = 19;
    localparam int DCS_BIT_AUX_DET = 20;
    localparam int DCS_BIT_TXN_PEND = 21;

    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [3:0] DCS_RST_ERR_EN = 4'h0;
    localparam logic [2:0] DCS_RST_MPS = 3'h0;
    localparam logic DCS_RST_AUX_PM = 1'b0;
    localparam logic [3:0] DCS_RST_ERR_FLAGS = 4'h0;
    localparam logic DCS_RST_AUX_DET = 1'b1;
    localparam logic [2:0] DCS_MPS_SUP_256 = 3'h1;
    localparam logic [2:0] DCS_MPS_SUP_512 = 3'h2;

    typedef enum logic {DCS_ST_IDLE, DCS_ST_ANSWER} dcs_apb_state_type;

endpackage
`default_nettype wire

// *** dcs_err_if.sv ***
// Interface carrying error events, clear strobes and logged flags.
// Assumes both ends run on clk_sys.
`default_nettype none
interface dcs_err_if;
    logic [3:0] errEvent;
    logic [3:0] clearMask;
    logic [3:0] flags;

    modport logger (input errEvent, input clearMask, output flags);
    modport owner (output errEvent, output clearMask, input flags);
endinterface
`default_nettype wire

// *** dcs_err_log.sv ***
// Error-detected flags, one per error class, write-one-to-clear.
// Assumes events and clears are single-cycle pulses on clk_sys.
`default_nettype none
module dcs_err_log
    import dcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    dcs_err_if.logger errIf
);

    logic [3:0] flags_reg;
    logic [3:0] flags_next;

    // ****************************************************************
    // Flag update
    // ****************************************************************
    // set wins clear
    always_comb
    begin
        flags_next = (flags_reg & ~errIf.clearMask) | errIf.errEvent;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            flags_reg <= DCS_RST_ERR_FLAGS;
        else
            flags_reg <= flags_next;
    end

    assign errIf.flags = flags_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence seqEvent;
        errIf.errEvent != 4'h0;
    endsequence

    a_flag_sets_event: assert property (seqEvent |=>
        ((flags_reg & $past(errIf.errEvent)) == $past(errIf.errEvent)))
        else $error("error event not logged");
    a_flag_w1c_clear: assert property (errIf.clearMask != 4'h0 |=>
        ((flags_reg & $past(errIf.clearMask) & ~$past(errIf.errEvent)) == 4'h0))
        else $error("write one did not clear flag");
    a_flag_holds_idle: assert property (
        (errIf.clearMask == 4'h0) && (errIf.errEvent == 4'h0) |=> flags_reg == $past(flags_reg))
        else $error("flag changed without cause");

endmodule
`default_nettype wire

// *** dcs_ctrl_status.sv ***
// Device control and device status register pair of one switch port, APB slave.
// Assumes error events are one-cycle pulses from clk_sys logic; strap and aux
// power level are asynchronous pins; rstnSticky is the cold reset only.
`default_nettype none
module dcs_ctrl_status
    import dcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic rstnSticky,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic corrErrEvent,
    input wire logic nonFatalErrEvent,
    input wire logic fatalErrEvent,
    input wire logic unsupReqEvent,
    input wire logic halfKilobytePayloadStrap,
    input wire logic auxPowerPin,
    output logic [3:0] errReportEn,
    output logic [2:0] maxPayloadCode,
    output logic auxPowerPmEn,
    output logic [3:0] errDetected
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [2:0] clampPayload(input logic [2:0] code, input logic [2:0] maxCode);
        clampPayload = (code > maxCode) ? maxCode : code;
    endfunction

    function automatic logic [2:0] supportedCode(input logic strap);
        supportedCode = strap ? DCS_MPS_SUP_512 : DCS_MPS_SUP_256;
    endfunction

    dcs_apb_state_type state_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] readWord;
    logic hit;
    logic setupPhase;
    logic writeNow;
    logic [3:0] errEn_reg;
    logic [2:0] mps_reg;
    logic [2:0] mps_next;
    logic auxPm_reg;
    logic [2:0] supMax_reg;
    logic [2:0] strapSync_reg;
    logic [2:0] auxSync_reg;
    logic auxDet_reg;

    dcs_err_if errIf ();

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign hit = (paddr == DCS_ADDR_CTRL_STATUS);
    assign setupPhase = psel && !penable;
    assign writeNow = (state_reg == DCS_ST_ANSWER) && psel && penable && pwrite && hit;

    // ****************************************************************
    // APB handshake: one access cycle, read word captured at setup
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= DCS_ST_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            case (state_reg)
                DCS_ST_IDLE:
                begin
                    if (setupPhase)
                    begin
                        state_reg <= DCS_ST_ANSWER;
                        pready_reg <= 1'b1;
                        pslverr_reg <= !hit;
                        prdata_reg <= (hit && !pwrite) ? readWord : 32'h0000_0000;
                    end
                end
                DCS_ST_ANSWER:
                begin
                    state_reg <= DCS_ST_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
                default:
                begin
                    state_reg <= DCS_ST_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
            endcase
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // ****************************************************************
    // Read word
    // ****************************************************************
    // hardwired zeros
    always_comb
    begin
        readWord = 32'h0000_0000;
        readWord[DCS_BIT_CORR_EN] = errEn_reg[0];
        readWord[DCS_BIT_NONFATAL_EN] = errEn_reg[1];
        readWord[DCS_BIT_FATAL_EN] = errEn_reg[2];
        readWord[DCS_BIT_UNSUP_EN] = errEn_reg[3];
        readWord[DCS_MPS_MSB:DCS_MPS_LSB] = mps_reg;
        readWord[DCS_BIT_AUX_PM] = auxPm_reg;
        readWord[DCS_ERR_MSB:DCS_ERR_LSB] = errIf.flags;
        readWord[DCS_BIT_AUX_DET] = auxDet_reg;
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Strap is static in practice; tracking it keeps the clamp honest after release
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            strapSync_reg <= 3'h0;
        else
            strapSync_reg <= {strapSync_reg[1:0], halfKilobytePayloadStrap};
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            auxSync_reg <= 3'h7;
        else
            auxSync_reg <= {auxSync_reg[1:0], auxPowerPin};
    end

    // ****************************************************************
    // Supported maximum payload
    // ****************************************************************
    // strap picks code
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            supMax_reg <= DCS_MPS_SUP_256;
        else if (strapSync_reg[1] == strapSync_reg[2])
            supMax_reg <= supportedCode(strapSync_reg[2]);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            auxDet_reg <= DCS_RST_AUX_DET;
        else if (auxSync_reg[1] == auxSync_reg[2])
            auxDet_reg <= auxSync_reg[2];
    end

    // ****************************************************************
    // Control fields
    // ****************************************************************
    // reporting enables
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            errEn_reg <= DCS_RST_ERR_EN;
        else if (writeNow && pstrb[0])
            errEn_reg <= pwdata[DCS_BIT_UNSUP_EN:DCS_BIT_CORR_EN];
    end

    always_comb
    begin
        mps_next = clampPayload(pwdata[DCS_MPS_MSB:DCS_MPS_LSB], supMax_reg);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            mps_reg <= DCS_RST_MPS;
        else if (writeNow && pstrb[0])
            mps_reg <= mps_next;
    end

    // sticky on cold reset
    // Only rstnSticky clears it, so a warm port reset leaves aux power enabled
    always_ff @(posedge clk_sys or negedge rstnSticky)
    begin
        if (!rstnSticky)
            auxPm_reg <= DCS_RST_AUX_PM;
        else if (rstn && writeNow && pstrb[1])
            auxPm_reg <= pwdata[DCS_BIT_AUX_PM];
    end

    // ****************************************************************
    // Error flags
    // ****************************************************************
    // events ignore enables
    assign errIf.errEvent = {unsupReqEvent, fatalErrEvent, nonFatalErrEvent, corrErrEvent};
    assign errIf.clearMask = (writeNow && pstrb[2]) ? pwdata[DCS_ERR_MSB:DCS_ERR_LSB] : 4'h0;

    dcs_err_log u_dcs_err_log (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .errIf(errIf)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign errReportEn = errEn_reg;
    assign maxPayloadCode = mps_reg;
    assign auxPowerPmEn = auxPm_reg;
    assign errDetected = errIf.flags;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence seqSetup;
        psel && !penable && (state_reg == DCS_ST_IDLE);
    endsequence

    sequence seqAnswer;
        pready ##1 !pready;
    endsequence

    sequence seqCtrlWrite;
        writeNow && pstrb[0];
    endsequence

    sequence seqNoCtrlWrite;
        seqSetup ##0 (!hit || !pwrite) ##1 1'b1;
    endsequence

    a_apb_one_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqSetup |=> seqAnswer)
        else $error("access not answered in one cycle");
    a_corr_enable_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqCtrlWrite |=> errReportEn[0] == $past(pwdata[0]))
        else $error("correctable enable not written");
    a_nonfatal_enable_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqCtrlWrite |=> errReportEn[1] == $past(pwdata[1]))
        else $error("non-fatal enable not written");
    a_fatal_enable_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqCtrlWrite |=> errReportEn[2] == $past(pwdata[2]))
        else $error("fatal enable not written");
    a_unsup_enable_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqCtrlWrite |=> errReportEn[3] == $past(pwdata[3]))
        else $error("unsupported request enable not written");
    a_payload_clamped: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqCtrlWrite |=> maxPayloadCode <= $past(supMax_reg))
        else $error("payload code above supported maximum");
    a_payload_stored: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqCtrlWrite ##0 (pwdata[7:5] <= supMax_reg) |=> maxPayloadCode == $past(pwdata[7:5]))
        else $error("legal payload code not stored");
    // Five samples: three sync stages and the register take four, agreement is seen at the register's edge
    a_strap_max_code: assert property (@(posedge clk_sys) disable iff (!rstn)
        halfKilobytePayloadStrap [*5] |=> supMax_reg == DCS_MPS_SUP_512)
        else $error("supported maximum does not follow strap");
    a_aux_pm_sticky: assert property (@(posedge clk_sys) disable iff (!rstnSticky)
        !rstn |=> auxPowerPmEn == $past(auxPowerPmEn))
        else $error("aux power enable lost in warm reset");
    a_hardwired_zeros: assert property (@(posedge clk_sys) disable iff (!rstn)
        pready |-> (prdata[31:21] == 11'h000) && (prdata[15:11] == 5'h00)
            && (prdata[9:8] == 2'h0) && !prdata[4])
        else $error("hardwired bit read nonzero");
    a_aux_detect_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqSetup ##0 hit && !pwrite |=> prdata[DCS_BIT_AUX_DET] == $past(auxDet_reg))
        else $error("aux detected bit misread");
    a_flags_read_back: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqSetup ##0 hit && !pwrite |=> prdata[19:16] == $past(errDetected))
        else $error("error flags misread");
    a_unmapped_error: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqSetup ##0 !hit |=> pslverr && pready && (prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    // Reset values land at the edge before release is sampled
    a_reset_ctrl_values: assert property (@(posedge clk_sys)
        $rose(rstn) |-> (errReportEn == DCS_RST_ERR_EN) && (maxPayloadCode == DCS_RST_MPS))
        else $error("control fields not at reset value");
    a_reset_flags_clear: assert property (@(posedge clk_sys)
        $rose(rstn) |-> errDetected == DCS_RST_ERR_FLAGS)
        else $error("error flags not cleared by reset");
    a_aux_det_reset: assert property (@(posedge clk_sys)
        $rose(rstn) |-> auxDet_reg == DCS_RST_AUX_DET)
        else $error("aux detected not set by reset");
    a_cold_reset_clear: assert property (@(posedge clk_sys)
        $rose(rstnSticky) |-> auxPowerPmEn == DCS_RST_AUX_PM)
        else $error("aux power enable not cleared by cold reset");
    a_aux_pm_write: assert property (@(posedge clk_sys) disable iff (!rstnSticky)
        writeNow && pstrb[1] |=> auxPowerPmEn == $past(pwdata[DCS_BIT_AUX_PM]))
        else $error("aux power enable not written");
    a_strobe_keeps_ctrl: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeNow && !pstrb[0] |=> $stable(errReportEn) && $stable(maxPayloadCode))
        else $error("control fields written without strobe");
    a_no_write_side: assert property (@(posedge clk_sys) disable iff (!rstn)
        seqNoCtrlWrite |=> $stable(errReportEn) && $stable(maxPayloadCode))
        else $error("read or unmapped access changed control");
    a_err_with_ready: assert property (@(posedge clk_sys) disable iff (!rstn)
        pslverr |-> pready)
        else $error("error response without ready");
    a_txn_pend_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        pready |-> !prdata[DCS_BIT_TXN_PEND])
        else $error("transactions pending read nonzero");
    a_ext_phantom_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        pready |-> (prdata[DCS_BIT_PHANTOM:DCS_BIT_EXT_TAG] == 2'h0))
        else $error("extended tag or phantom bit read nonzero");
    a_snoop_order_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        pready |-> !prdata[DCS_BIT_NO_SNOOP] && !prdata[DCS_BIT_RELAXED])
        else $error("no-snoop or relaxed ordering bit read nonzero");

endmodule
`default_nettype wire

// *** tb_pcie_port_device_ctrl_status.sv ***
// Self-checking bench for the port device control and status register pair.
// Assumes dcs_pkg and the design files compile first; one clock, APB master here.
`default_nettype none
module tb_pcie_port_device_ctrl_status
    import dcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Stimulus signals and reference model
    // ****************************************************************
    logic clk_sys, rstn, rstnSticky, psel, penable, pwrite, pready, pslverr;
    logic strap, auxPin, auxPowerPmEn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, r, d;
    logic [3:0] pstrb, errEv, errReportEn, errDetected, mEn, mFlags;
    logic [2:0] maxPayloadCode, mMps, mSup;
    logic mAux, mAuxDet;
    int n_fail, n_compared, i;

    dcs_ctrl_status u_dcs_ctrl_status (
        .clk_sys(clk_sys), .rstn(rstn), .rstnSticky(rstnSticky), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .corrErrEvent(errEv[0]), .nonFatalErrEvent(errEv[1]), .fatalErrEvent(errEv[2]),
        .unsupReqEvent(errEv[3]), .halfKilobytePayloadStrap(strap), .auxPowerPin(auxPin),
        .errReportEn(errReportEn), .maxPayloadCode(maxPayloadCode),
        .auxPowerPmEn(auxPowerPmEn), .errDetected(errDetected)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Shift several steps per draw, neighbouring draws are less alike
    function automatic logic [31:0] rnd();
        repeat (7) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [31:0] expWord();
        return {10'h000, 1'b0, mAuxDet, mFlags, 1'b0, 3'h0, 1'b0, mAux, 2'h0, mMps, 1'b0, mEn};
    endfunction

    task automatic summarize();
        if (n_fail == 0 && n_compared > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpFlag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Outputs are looked at mid-cycle, after the edge's updates landed
    task automatic cmpPorts();
        @(negedge clk_sys);
        cmpWord({20'h0, errReportEn, maxPayloadCode, auxPowerPmEn, errDetected},
            {20'h0, mEn, mMps, mAux, mFlags});
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
        input logic [3:0] s, output logic [31:0] rd, output logic er);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
            begin
                break;
            end
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
        begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic doWrite(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
        logic [31:0] rd;
        logic er;
        apb(a, 1'b1, wd, s, rd, er);
        cmpFlag(er, a != DCS_ADDR_CTRL_STATUS);
        if (a == DCS_ADDR_CTRL_STATUS)
        begin
            if (s[0])
            begin
                mEn = wd[3:0];
                mMps = (wd[7:5] > mSup) ? mSup : wd[7:5];
            end
            if (s[1])
            begin
                mAux = wd[10];
            end
            if (s[2])
            begin
                mFlags = mFlags & ~wd[19:16];
            end
        end
        cmpPorts();
    endtask

    task automatic doRead(input logic [11:0] a);
        logic [31:0] rd;
        logic er;
        apb(a, 1'b0, 32'h0000_0000, 4'h0, rd, er);
        cmpFlag(er, a != DCS_ADDR_CTRL_STATUS);
        cmpWord(rd, (a == DCS_ADDR_CTRL_STATUS) ? expWord() : 32'h0000_0000);
    endtask

    task automatic pulse(input logic [3:0] m);
        @(posedge clk_sys);
        errEv <= m;
        @(posedge clk_sys);
        errEv <= 4'h0;
        mFlags = mFlags | m;
        cmpPorts();
    endtask

    // Pins pass a synchroniser, so give them time to settle
    task automatic pins(input logic s, input logic a);
        strap <= s;
        auxPin <= a;
        repeat (8) @(posedge clk_sys);
        mSup = s ? DCS_MPS_SUP_512 : DCS_MPS_SUP_256;
        mAuxDet = a;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {rstn, rstnSticky, psel, penable, pwrite, strap} = 6'h00;
        auxPin = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        errEv = 4'h0;
        seed = 32'h0000_0006;
        n_fail = 0;
        n_compared = 0;
        {mEn, mFlags, mMps, mAux, mAuxDet, mSup} = {4'h0, 4'h0, 3'h0, 1'b0, 1'b1, 3'h1};
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rstnSticky <= 1'b1;
        pins(1'b0, 1'b1);
        doRead(DCS_ADDR_CTRL_STATUS);
        for (i = 0; i < 4; i++)
        begin
            pulse(4'h1 << i);
        end
        doRead(DCS_ADDR_CTRL_STATUS);
        // Random pins, events, strobes and payload codes beyond the clamp
        for (i = 0; i < 48; i++)
        begin
            r = rnd();
            if (r[28:27] == 2'h0)
            begin
                pins(r[29], r[30]);
            end
            pulse(r[26:23]);
            d = rnd();
            doWrite(DCS_ADDR_CTRL_STATUS, d, r[31] ? 4'hF : r[3:0]);
            doRead(DCS_ADDR_CTRL_STATUS);
        end
        doWrite(DCS_ADDR_CTRL_STATUS, 32'hFFFF_FFFF, 4'hF);
        doRead(DCS_ADDR_CTRL_STATUS);
        doWrite(12'h0CC, 32'h0000_0000, 4'hF);
        doRead(12'h0CC);
        doRead(DCS_ADDR_CTRL_STATUS);
        pulse(4'hF);
        // Warm reset keeps the sticky aux power enable
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        {mEn, mMps, mFlags} = {4'h0, 3'h0, 4'h0};
        pins(strap, auxPin);
        doRead(DCS_ADDR_CTRL_STATUS);
        cmpPorts();
        @(posedge clk_sys);
        rstnSticky <= 1'b0;
        @(posedge clk_sys);
        rstnSticky <= 1'b1;
        mAux = 1'b0;
        doRead(DCS_ADDR_CTRL_STATUS);
        summarize();
    end
endmodule
`default_nettype wire
